// ===== dv/drs_periph.sv
// request peripheral model: holds its request low while it has units left
// assumes acknowledge_strobe is active high and the pin has a pull-up
// assumes every unit holds acknowledge for unit_len states, units may run back to back
`timescale 1ns/1ps
`default_nettype none
module drs_periph #(
	parameter int NUM_CH = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [NUM_CH-1:0] load,
	input wire logic [7:0] load_val,
	input wire logic [NUM_CH-1:0] acknowledge_strobe,
	input wire logic [7:0] unit_len,
	output logic [NUM_CH-1:0] request_pin_n,
	output logic [7:0] unit_cnt,
	output logic [7:0] ack_len
);
	logic [7:0] need [NUM_CH];
	logic [NUM_CH-1:0] ack_q;
	logic [7:0] run_len, st;
	logic step;
	// a unit starts at an acknowledge rise or after unit_len states of a long run
	always_comb step = (|acknowledge_strobe) && (st == 8'h00 || st == unit_len);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) st <= 8'h00;
		else st <= !(|acknowledge_strobe) ? 8'h00 : (step ? 8'h01 : st + 8'h01);
	end
	// one unit consumed per unit start; the count of unit starts is kept for the bench
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= '0;
			unit_cnt <= 8'h00;
			for (int i = 0; i < NUM_CH; i++) need[i] <= 8'h00;
		end else begin
			ack_q <= acknowledge_strobe;
			for (int i = 0; i < NUM_CH; i++) begin
				if (load[i]) need[i] <= load_val;
				else if (acknowledge_strobe[i] && step && need[i] != 8'h00) need[i] <= need[i] - 8'h01;
			end
			if (step) unit_cnt <= unit_cnt + 8'h01;
		end
	end
	// width of the last acknowledge, to see the programmed cycle length
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run_len <= 8'h00;
			ack_len <= 8'h00;
		end else begin
			run_len <= (|acknowledge_strobe) ? run_len + 8'h01 : 8'h00;
			if (|ack_q && !(|acknowledge_strobe)) ack_len <= run_len;
		end
	end
	// released pin floats high through the pull-up
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) request_pin_n[i] = (need[i] == 8'h00);
	end
endmodule // drs_periph
`default_nettype wire

// ===== dv/drs_top_tb.sv
// self-checking bench for drs_top with the request peripheral model
// assumes the offsets and bit positions of drs_cfg.svh, clk at 25 MHz
`timescale 1ns/1ps
`default_nettype none
`include "drs_cfg.svh"
module drs_top_tb;
	logic clk, rst_b, reg_wr, reg_rd, nmi_event, addr_error_event, cpu_cycle_end;
	logic transfer_end_irq, dma_busy, dma_read, dma_write;
	logic [7:0] reg_addr, load_val, unit_cnt, ack_len, base, unit_len;
	logic [31:0] reg_wdata, reg_rdata;
	logic [3:0] load, request_pin_n, acknowledge_strobe;
	int errors, comparisons;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} drs_row_t;
	// address, write value, read-back value
	drs_row_t rows [7] = '{'{8'h00, 32'h00001000, 32'h00001000},
		'{8'h14, 32'hffffffff, 32'hffffffff}, '{8'h28, 32'h00012345, 32'h00002345},
		'{8'h44, 32'h000000ff, 32'h0000000f}, '{8'h48, 32'h00000013, 32'h00000003},
		'{8'h3c, 32'h000003fe, 32'h000003fc}, '{8'h4c, 32'h000000ff, 32'h00000000}};
	drs_top #(.NUM_CH(4), .CNT_W(16)) u_drs_top (.clk(clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .request_pin_n(request_pin_n), .nmi_event(nmi_event),
		.addr_error_event(addr_error_event), .cpu_cycle_end(cpu_cycle_end),
		.acknowledge_strobe(acknowledge_strobe), .transfer_end_irq(transfer_end_irq),
		.dma_busy(dma_busy), .dma_read(dma_read), .dma_write(dma_write));
	drs_periph #(.NUM_CH(4)) u_drs_periph (.clk(clk), .rst_b(rst_b), .load(load),
		.load_val(load_val), .acknowledge_strobe(acknowledge_strobe), .unit_len(unit_len),
		.request_pin_n(request_pin_n), .unit_cnt(unit_cnt), .ack_len(ack_len));
	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(n, reg_rdata, e);
	endtask
	task automatic need(input int ch, input logic [7:0] v);
		@(posedge clk);
		load <= 4'h1 << ch;
		load_val <= v;
		@(posedge clk);
		load <= 4'h0;
	endtask
	task automatic win;
		repeat (100) @(posedge clk);
	endtask
	// program a channel, let the peripheral ask, then check units, flags and count
	task automatic run(input int ch, input logic [31:0] c, input logic [15:0] n,
		input logic [7:0] q, input logic [7:0] u, input logic te, input string nm);
		logic [7:0] b;
		b = 8'(ch * 16);
		base = unit_cnt;
		wr(b + `CNT_OFF, {16'h0000, n});
		wr(b + `CTRL_OFF, c);
		need(ch, q);
		win;
		chk(nm, {24'h0, 8'(unit_cnt - base)}, {24'h0, u});
		chk("busy_idle", {31'h0, dma_busy}, 32'h0);
		rd(b + `CTRL_OFF, c | {30'h0, te, 1'b0}, nm);
		rd(b + `CNT_OFF, {16'h0000, n - {8'h00, u}}, nm);
	endtask
	// stop a long level burst on channel 1 one unit in; the end flag must stay clear
	task automatic halt_mid(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] ce, input string nm);
		wr(`WAITS_ADDR, 32'h7);
		unit_len <= 8'h08;
		base = unit_cnt;
		wr(8'h18, 32'h5);
		wr(8'h1c, 32'h009);
		need(1, 8'h05);
		for (int i = 0; i < 60 && unit_cnt == base; i++) @(posedge clk);
		wr(a, d);
		win;
		chk(nm, {24'h0, 8'(unit_cnt - base)}, 32'h1);
		rd(8'h1c, ce, nm);
		rd(8'h18, 32'h4, nm);
		need(1, 8'h00);
		wr(8'h1c, 32'h0);
		wr(`OPC_ADDR, 32'h1);
		wr(`WAITS_ADDR, 32'h0);
		unit_len <= 8'h01;
	endtask
	// cut a hang short well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_of_test;
	end
	initial begin
		{errors, comparisons} = '0;
		{rst_b, reg_wr, reg_rd, nmi_event, addr_error_event, cpu_cycle_end} = '0;
		{reg_addr, reg_wdata, load, load_val} = '0;
		unit_len = 8'h01;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk("irq_rst", {31'h0, transfer_end_irq}, 32'h0);
		chk("ack_rst", {28'h0, acknowledge_strobe}, 32'h0);
		foreach (rows[i]) begin
			rd(rows[i].a, 32'h0, "reset");
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e, "rw");
		end
		wr(8'h3c, 32'h0);
		wr(`WAITD_ADDR, 32'h0);
		wr(`WAITS_ADDR, 32'h0);
		wr(`OPC_ADDR, 32'h1);
		run(0, 32'h005, 16'h2, 8'h02, 8'h02, 1'b1, "cs_level");
		chk("irq", {31'h0, transfer_end_irq}, 32'h1);
		base = unit_cnt;
		need(0, 8'h01);
		win;
		chk("te_block", {24'h0, 8'(unit_cnt - base)}, 32'h0);
		run(0, 32'h005, 16'h1, 8'h01, 8'h01, 1'b1, "te_clear");
		run(0, 32'h011, 16'h3, 8'h03, 8'h01, 1'b0, "cs_edge");
		need(0, 8'h00);
		run(1, 32'h019, 16'h3, 8'h01, 8'h03, 1'b1, "burst_edge");
		wr(`WAITS_ADDR, 32'h7);
		unit_len <= 8'h08;
		run(1, 32'h009, 16'h4, 8'h02, 8'h02, 1'b0, "burst_level");
		// two back-to-back units of eight states each
		chk("ack_len", {24'h0, ack_len}, 32'h10);
		wr(`WAITS_ADDR, 32'h0);
		unit_len <= 8'h01;
		halt_mid(8'h1c, 32'h008, 32'h008, "ch_off");
		halt_mid(`OPC_ADDR, 32'h0, 32'h009, "me_off");
		@(posedge clk);
		nmi_event <= 1'b1;
		@(posedge clk);
		nmi_event <= 1'b0;
		rd(`OPC_ADDR, 32'h3, "nmi_idle");
		run(0, 32'h005, 16'h1, 8'h01, 8'h00, 1'b0, "nmi_stop");
		wr(`OPC_ADDR, 32'h1);
		run(0, 32'h005, 16'h1, 8'h01, 8'h01, 1'b1, "resume");
		@(posedge clk);
		addr_error_event <= 1'b1;
		@(posedge clk);
		addr_error_event <= 1'b0;
		rd(`OPC_ADDR, 32'h5, "ae_flag");
		wr(`OPC_ADDR, 32'h1);
		rd(`OPC_ADDR, 32'h1, "ae_clear");
		end_of_test;
	end
endmodule // drs_top_tb
`default_nettype wire

// ===== hdl/drs_sampler.sv
// request sampler for one channel: synchroniser, edge catch and sampling phases
// assumes engine events arrive as one-cycle pulses on the channel link
`timescale 1ns/1ps
`default_nettype none
module drs_sampler (
	input wire logic clk,
	input wire logic rst_n,
	drs_ch_if.smp ch
);
	logic s1, s2, s3, edge_seen, hit, sample, pt;
	drs_pkg::drs_smp_t phase;

	// two-stage synchroniser, s3 only feeds the edge compare
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else begin
			s1 <= ch.pin_n; // see [RULE19]
			s2 <= s1;
			s3 <= s2;
		end
	end

	// when the pin is looked at depends on phase
	always_comb begin
		pt = ch.dual ? ch.read_start : ch.cycle_end; // see [RULE8] see [RULE9]
		case (phase)
			drs_pkg::DRS_EVERY: sample = 1'b1; // see [RULE7]
			drs_pkg::DRS_HOLD: sample = ch.resample_pt; // see [RULE4]
			drs_pkg::DRS_SECOND: sample = ch.ack_state; // see [RULE5]
			// a miss counts at once so the engine sees it at this cycle end
			drs_pkg::DRS_POINT: sample = pt | (s2 & ~ch.edge_m); // see [RULE17]
			default: sample = 1'b0; // see [RULE6]
		endcase
		hit = ch.edge_m ? edge_seen : ~s2; // see [RULE3]
	end

	// a caught edge is spent once sampled; a new edge wins over the spend
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) edge_seen <= 1'b0;
		// only edges seen in edge mode count, so a level run leaves no stale edge
		else edge_seen <= (s3 & ~s2 & ch.edge_m & ch.armed)
			| (edge_seen & ~(sample & ch.edge_m)); // see [RULE3]
	end

	// phase walk and pending request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= drs_pkg::DRS_EVERY;
			ch.pending <= 1'b0;
		end else if (!ch.armed || ch.burst_done) begin
			phase <= drs_pkg::DRS_EVERY;
			ch.pending <= 1'b0;
		end else if (sample && hit) begin
			ch.pending <= 1'b1;
			if (phase == drs_pkg::DRS_EVERY)
				phase <= !ch.burst ? drs_pkg::DRS_HOLD : (ch.edge_m ? drs_pkg::DRS_RUN : drs_pkg::DRS_POINT);
			else if (phase == drs_pkg::DRS_SECOND)
				phase <= drs_pkg::DRS_HOLD;
		end else begin
			if (ch.take && !ch.burst) ch.pending <= 1'b0;
			if (sample) begin
				case (phase)
					drs_pkg::DRS_HOLD: phase <= drs_pkg::DRS_SECOND; // see [RULE5]
					drs_pkg::DRS_SECOND: phase <= drs_pkg::DRS_EVERY; // see [RULE5]
					drs_pkg::DRS_POINT: begin
						phase <= drs_pkg::DRS_EVERY; // see [RULE9] see [RULE17]
						ch.pending <= 1'b0;
					end
					default: phase <= phase;
				endcase
			end
		end
	end

	run_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE6]
		phase == drs_pkg::DRS_RUN && ch.armed && !ch.burst_done |=> ch.pending)
		else $error("burst edge request dropped before end");
	second_try_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		phase == drs_pkg::DRS_HOLD && ch.armed && !ch.burst_done && ch.resample_pt && !hit
		|=> phase == drs_pkg::DRS_SECOND) else $error("missed resample did not move on");
	point_miss_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
		phase == drs_pkg::DRS_POINT && pt && !hit && ch.armed && !ch.burst_done
		|=> phase == drs_pkg::DRS_EVERY && !ch.pending) else $error("burst level miss kept request");
	second_c: cover property (@(posedge clk) disable iff (!rst_n) phase == drs_pkg::DRS_SECOND);
	run_c: cover property (@(posedge clk) disable iff (!rst_n) phase == drs_pkg::DRS_RUN);
endmodule // drs_sampler
`default_nettype wire

// ===== hdl/drs_top.sv
// dma request sampling and transfer end control, register port and engine
// assumes strobes synchronous to clk, one-cycle nmi and address error pulses
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "drs_cfg.svh"

// Summary of operation
// [RULE1] bus cycle lengths come from dual or single wait registers
// [RULE2] request sampled before clock rise, cycle starts two states later at earliest
// [RULE3] cycle steal: same sampling for edge and level; edge sampled once
// [RULE4] cycle steal: hold sampling, resample third state after pre-ack cycle
// [RULE5] cycle steal: on miss, sample at next ack state, then every state
// [RULE6] burst edge: keep transferring until end, pin ignored meanwhile
// [RULE7] burst edge: after finish, sample every state until end flag cleared
// [RULE8] burst level single: resample at end of each cpu or dma cycle
// [RULE9] burst level dual: resample at read start; miss means every state
// [RULE10] count reaching zero sets end flag and interrupt if enabled
// [RULE11] clearing channel enable stops channel, end flag untouched
// [RULE12] nmi or address error sets flag, stops all, no end flag
// [RULE13] software clears the flag then re-enables channels to resume
// [RULE14] dual read address error finishes paired write and updates registers
// [RULE15] clearing master enable aborts all at end of current cycle
// [RULE16] bus mode field picks burst or cycle steal per channel
// [RULE17] burst level: pin high releases bus after current cycle
// [RULE18] nmi flag sets even with no channel active
// [RULE19] request pin synchronised through two stages before use
// [RULE20] end flag sticky until cleared and blocks the channel
module drs_top #(
	parameter int NUM_CH = 4,
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [NUM_CH-1:0] request_pin_n,
	input wire logic nmi_event,
	input wire logic addr_error_event,
	input wire logic cpu_cycle_end,
	output logic [NUM_CH-1:0] acknowledge_strobe,
	output logic transfer_end_irq,
	output logic dma_busy,
	output logic dma_read,
	output logic dma_write
);
	localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

	// the map leaves room for four channels below the global registers
	if (NUM_CH < 1 || NUM_CH > 4 || CNT_W < 2 || CNT_W > 32) begin : g_bad_param
		$error("drs_top: NUM_CH must be 1..4 and CNT_W 2..32");
	end

	logic rst_q1, rst_n;
	logic [NUM_CH-1:0] en, te, ie, burst, edge_m, dual, ackw, word, sinc, dinc, pend, ready;
	logic [31:0] src [NUM_CH];
	logic [31:0] dst [NUM_CH];
	logic [CNT_W-1:0] cnt [NUM_CH];
	logic me, nmi_f, ae_f, ae_keep, fin_write, stop, last_unit;
	logic unit_done, end_burst, take, rs_start, dma_cyc_end;
	logic [`WAIT_W-1:0] wait_dual, wait_single, wcnt, next_wcnt, cyc_load;
	logic [1:0] rcnt;
	logic [CH_W-1:0] cur, next_cur;
	drs_pkg::drs_eng_t state, next_state, prev_state;

	function automatic logic at(input logic [`ADDR_W-1:0] a, input int i,
		input logic [`ADDR_W-1:0] off);
		return a == (`ADDR_W'(i * `CH_STRIDE) + off);
	endfunction

	function automatic logic [CH_W-1:0] first_set(input logic [NUM_CH-1:0] v);
		logic [CH_W-1:0] idx;
		idx = '0;
		for (int i = NUM_CH - 1; i >= 0; i--)
			if (v[i]) idx = CH_W'(i);
		return idx;
	endfunction

	// reset released through two flops, asserted at once
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// one sampler per channel, joined over the channel link
	drs_ch_if chi[NUM_CH] ();
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		assign chi[g].pin_n = request_pin_n[g];
		assign chi[g].armed = en[g] & me;
		assign chi[g].burst = burst[g]; // see [RULE16]
		assign chi[g].edge_m = edge_m[g];
		assign chi[g].dual = dual[g];
		assign chi[g].ack_state = acknowledge_strobe[g];
		assign chi[g].resample_pt = (rcnt == `RESAMPLE_STATE) && (cur == CH_W'(g)); // see [RULE4]
		assign chi[g].cycle_end = cpu_cycle_end | dma_cyc_end; // see [RULE8]
		assign chi[g].read_start = (state == drs_pkg::DRS_READ) && (prev_state != drs_pkg::DRS_READ)
			&& (cur == CH_W'(g)); // see [RULE9]
		assign chi[g].take = take && (next_cur == CH_W'(g));
		assign chi[g].burst_done = end_burst && (cur == CH_W'(g));
		assign pend[g] = chi[g].pending;
		drs_sampler u_smp (
			.clk(clk),
			.rst_n(rst_n),
			.ch(chi[g])
		);
	end

	// a channel may start only with everything clear
	always_comb begin
		for (int i = 0; i < NUM_CH; i++)
			ready[i] = en[i] & ~te[i] & pend[i] & me & ~nmi_f & ~ae_f // see [RULE20] see [RULE12]
				& (cnt[i] != '0);
	end

	// stop terms and the cycle length of the channel in hand
	always_comb begin
		stop = ~me | nmi_f | ae_f | ~en[cur]; // see [RULE11] see [RULE15]
		fin_write = ae_keep | ((state == drs_pkg::DRS_READ) & addr_error_event); // see [RULE14]
		last_unit = cnt[cur] == CNT_W'(1);
		dma_cyc_end = (state == drs_pkg::DRS_READ || state == drs_pkg::DRS_WRITE
			|| state == drs_pkg::DRS_SINGLE) && (wcnt == '0);
		cyc_load = dual[cur] ? wait_dual : wait_single; // see [RULE1]
	end

	// engine next state: lead states, then read and write or a single cycle
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_wcnt = (wcnt == '0) ? wcnt : wcnt - `WAIT_W'(1);
		unit_done = 1'b0;
		take = 1'b0;
		case (state)
			drs_pkg::DRS_IDLE: begin
				if (|ready) begin
					next_cur = first_set(ready);
					next_state = drs_pkg::DRS_LEAD;
					next_wcnt = `WAIT_W'(`LEAD_LOAD); // see [RULE2]
					take = 1'b1;
				end
			end
			drs_pkg::DRS_LEAD: begin
				if (stop) begin
					next_state = drs_pkg::DRS_IDLE;
				end else if (wcnt == '0) begin
					next_state = dual[cur] ? drs_pkg::DRS_READ : drs_pkg::DRS_SINGLE;
					next_wcnt = cyc_load;
				end
			end
			drs_pkg::DRS_READ: begin
				if (wcnt == '0) begin
					if (stop && !fin_write) begin
						next_state = drs_pkg::DRS_IDLE; // see [RULE12] see [RULE15]
					end else begin
						next_state = drs_pkg::DRS_WRITE; // see [RULE14]
						next_wcnt = wait_dual; // see [RULE1]
					end
				end
			end
			drs_pkg::DRS_WRITE, drs_pkg::DRS_SINGLE: begin
				if (wcnt == '0) begin
					unit_done = 1'b1;
					if (burst[cur] && !stop && !fin_write && !last_unit && !addr_error_event
						&& pend[cur]) begin // see [RULE6] see [RULE17]
						next_state = dual[cur] ? drs_pkg::DRS_READ : drs_pkg::DRS_SINGLE;
						next_wcnt = cyc_load;
					end else begin
						next_state = drs_pkg::DRS_IDLE;
					end
				end
			end
			default: next_state = drs_pkg::DRS_IDLE;
		endcase
		end_burst = (state != drs_pkg::DRS_IDLE) && (next_state == drs_pkg::DRS_IDLE) && burst[cur];
		rs_start = ((state == drs_pkg::DRS_IDLE) && (next_state == drs_pkg::DRS_LEAD)
			&& !(dual[next_cur] && ackw[next_cur]))
			|| ((state == drs_pkg::DRS_READ) && (next_state == drs_pkg::DRS_WRITE) && ackw[cur]);
	end

	// engine registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= drs_pkg::DRS_IDLE;
			prev_state <= drs_pkg::DRS_IDLE;
			cur <= '0;
			wcnt <= '0;
			ae_keep <= 1'b0;
		end else begin
			state <= next_state;
			prev_state <= state;
			cur <= next_cur;
			wcnt <= next_wcnt;
			// a read that faulted still owes its write
			ae_keep <= (next_state != drs_pkg::DRS_IDLE) && fin_write;
		end
	end

	// counts states from the end of the cycle before the acknowledged one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rcnt <= '0;
		else if (rs_start) rcnt <= 2'h1; // see [RULE4]
		else if (rcnt != '0 && rcnt != `RESAMPLE_STATE) rcnt <= rcnt + 2'h1;
		else rcnt <= '0;
	end

	// channel control bits; end flag set by hardware wins over a software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{en, ie, burst, edge_m, dual, ackw, word, sinc, dinc, te} <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (reg_wr && at(reg_addr, i, `CTRL_OFF)) begin
					en[i] <= reg_wdata[`C_EN]; // see [RULE13]
					ie[i] <= reg_wdata[`C_IE];
					burst[i] <= reg_wdata[`C_BURST]; // see [RULE16]
					edge_m[i] <= reg_wdata[`C_EDGE];
					dual[i] <= reg_wdata[`C_DUAL];
					ackw[i] <= reg_wdata[`C_ACKW];
					word[i] <= reg_wdata[`C_WORD];
					sinc[i] <= reg_wdata[`C_SINC];
					dinc[i] <= reg_wdata[`C_DINC];
				end
				te[i] <= (unit_done && last_unit && cur == CH_W'(i)) // see [RULE10] see [RULE20]
					| (te[i] & ~(reg_wr && at(reg_addr, i, `CTRL_OFF) && !reg_wdata[`C_TE]));
			end
		end
	end

	// addresses and count move only when a whole unit completes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				src[i] <= '0;
				dst[i] <= '0;
				cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (unit_done && cur == CH_W'(i)) begin // see [RULE12] see [RULE14]
					if (sinc[i]) src[i] <= src[i] + (word[i] ? `STEP_WORD : `STEP_BYTE);
					if (dinc[i]) dst[i] <= dst[i] + (word[i] ? `STEP_WORD : `STEP_BYTE);
					cnt[i] <= cnt[i] - CNT_W'(1);
				end else begin
					if (reg_wr && at(reg_addr, i, `SRC_OFF)) src[i] <= reg_wdata;
					if (reg_wr && at(reg_addr, i, `DST_OFF)) dst[i] <= reg_wdata;
					if (reg_wr && at(reg_addr, i, `CNT_OFF)) cnt[i] <= reg_wdata[CNT_W-1:0];
				end
			end
		end
	end

	// global control; events always set their flags, even with all channels idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			me <= 1'b0;
			nmi_f <= 1'b0;
			ae_f <= 1'b0;
			wait_dual <= `WAIT_RST;
			wait_single <= `WAIT_RST;
		end else begin
			if (reg_wr && reg_addr == `OPC_ADDR) me <= reg_wdata[`O_ME]; // see [RULE15]
			nmi_f <= nmi_event // see [RULE18] see [RULE12]
				| (nmi_f & ~(reg_wr && reg_addr == `OPC_ADDR && !reg_wdata[`O_NMI]));
			ae_f <= addr_error_event // see [RULE12]
				| (ae_f & ~(reg_wr && reg_addr == `OPC_ADDR && !reg_wdata[`O_AE]));
			if (reg_wr && reg_addr == `WAITD_ADDR) wait_dual <= reg_wdata[`WAIT_W-1:0];
			if (reg_wr && reg_addr == `WAITS_ADDR) wait_single <= reg_wdata[`WAIT_W-1:0];
		end
	end

	// read data for one cycle after the strobe, zero otherwise and when unmapped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_rd) begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (at(reg_addr, i, `SRC_OFF)) reg_rdata <= src[i];
					if (at(reg_addr, i, `DST_OFF)) reg_rdata <= dst[i];
					if (at(reg_addr, i, `CNT_OFF)) reg_rdata <= 32'(cnt[i]);
					if (at(reg_addr, i, `CTRL_OFF))
						reg_rdata <= {22'h0, dinc[i], sinc[i], word[i], ackw[i], dual[i],
							edge_m[i], burst[i], ie[i], te[i], en[i]};
				end
				if (reg_addr == `OPC_ADDR) reg_rdata <= {29'h0, ae_f, nmi_f, me};
				if (reg_addr == `WAITD_ADDR) reg_rdata <= 32'(wait_dual);
				if (reg_addr == `WAITS_ADDR) reg_rdata <= 32'(wait_single);
			end
		end
	end

	// pin-side outputs registered from the next engine state, the interrupt from the end flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acknowledge_strobe <= '0;
			transfer_end_irq <= 1'b0;
			dma_busy <= 1'b0;
			dma_read <= 1'b0;
			dma_write <= 1'b0;
		end else begin
			acknowledge_strobe <= ((next_state == drs_pkg::DRS_SINGLE)
				|| (next_state == drs_pkg::DRS_READ && !ackw[next_cur])
				|| (next_state == drs_pkg::DRS_WRITE && ackw[next_cur]))
				? NUM_CH'(1) << next_cur : '0;
			transfer_end_irq <= |(te & ie); // see [RULE10]
			dma_busy <= next_state != drs_pkg::DRS_IDLE;
			dma_read <= next_state == drs_pkg::DRS_READ;
			dma_write <= next_state == drs_pkg::DRS_WRITE || next_state == drs_pkg::DRS_SINGLE;
		end
	end

	lead_gap_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE2]
		state == drs_pkg::DRS_IDLE && next_state == drs_pkg::DRS_LEAD
		|=> (state == drs_pkg::DRS_LEAD) [*2]) else $error("lead shorter than two states");
	wait_len_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE1]
		state == drs_pkg::DRS_LEAD && next_state == drs_pkg::DRS_SINGLE
		|=> wcnt == wait_single) else $error("single cycle length not from its wait register");
	te_cause_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE11]
		|(te & ~$past(te)) |-> $past(unit_done && last_unit)) else $error("end flag set without last unit");
	te_set_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
		unit_done && last_unit |=> |(te & ~$past(te))) else $error("end flag not set on last unit");
	irq_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
		|(te & ie) |=> transfer_end_irq) else $error("end interrupt missing");
	nmi_halt_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE12]
		nmi_event |-> ##[1:40] state == drs_pkg::DRS_IDLE) else $error("nmi did not halt engine");
	me_abort_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE15]
		!me && dma_cyc_end && !fin_write |=> state == drs_pkg::DRS_IDLE) else $error("no abort on master off");
	ae_finish_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE14]
		state == drs_pkg::DRS_READ && wcnt == '0 && fin_write
		|=> state == drs_pkg::DRS_WRITE) else $error("faulted read lost its write");
	te_block_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE20]
		state == drs_pkg::DRS_IDLE && next_state == drs_pkg::DRS_LEAD |-> !te[next_cur])
		else $error("channel started with end flag set");
	ae_fin_c: cover property (@(posedge clk) disable iff (!rst_n) ae_keep && unit_done);
	burst_c: cover property (@(posedge clk) disable iff (!rst_n)
		unit_done && next_state != drs_pkg::DRS_IDLE);
	te_c: cover property (@(posedge clk) disable iff (!rst_n) transfer_end_irq);
endmodule // drs_top
`default_nettype wire

// ===== include/drs_cfg.svh
// register map, field positions and timing counts of the dma request block
// assumes byte addresses on an 8-bit register port with 32-bit data
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH
`define ADDR_W 8
`define CH_STRIDE 8'h10
`define SRC_OFF 8'h00
`define DST_OFF 8'h04
`define CNT_OFF 8'h08
`define CTRL_OFF 8'h0c
`define OPC_ADDR 8'h40
`define WAITD_ADDR 8'h44
`define WAITS_ADDR 8'h48
`define C_EN 0
`define C_TE 1
`define C_IE 2
`define C_BURST 3
`define C_EDGE 4
`define C_DUAL 5
`define C_ACKW 6
`define C_WORD 7
`define C_SINC 8
`define C_DINC 9
`define O_ME 0
`define O_NMI 1
`define O_AE 2
`define WAIT_W 4
`define WAIT_RST 4'h0
`define LEAD_LOAD 2'h1
`define RESAMPLE_STATE 2'h3
`define STEP_BYTE 32'h1
`define STEP_WORD 32'h2
`endif

// ===== include/drs_ch_if.sv
// channel link between the transfer engine and one request sampler
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface drs_ch_if;
	logic pin_n;
	logic armed;
	logic burst;
	logic edge_m;
	logic dual;
	logic ack_state;
	logic resample_pt;
	logic cycle_end;
	logic read_start;
	logic take;
	logic burst_done;
	logic pending;
	modport eng(output pin_n, armed, burst, edge_m, dual, ack_state, resample_pt, cycle_end,
		read_start, take, burst_done, input pending);
	modport smp(input pin_n, armed, burst, edge_m, dual, ack_state, resample_pt, cycle_end,
		read_start, take, burst_done, output pending);
endinterface
`default_nettype wire

// ===== include/drs_pkg.sv
// state types shared by the request engine and the per-channel sampler
// assumes nothing beyond a systemverilog compiler
package drs_pkg;
	typedef enum logic [2:0] {
		DRS_IDLE = 3'h0, DRS_LEAD = 3'h1, DRS_READ = 3'h2, DRS_WRITE = 3'h3, DRS_SINGLE = 3'h4
	} drs_eng_t;
	typedef enum logic [2:0] {
		DRS_EVERY = 3'h0, DRS_HOLD = 3'h1, DRS_SECOND = 3'h2, DRS_RUN = 3'h3, DRS_POINT = 3'h4
	} drs_smp_t;
endpackage
